//--- ring_feedback_conversion.sv
// ring feedback conversion stage and its result fifo
// assumes ring register reads answer one pclk after the request
`timescale 1ns/100ps

// result fifo, flip-flop storage, valid/ready both sides
module result_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // honest flags straight from the count
    assign in_ready  = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage written by index
    always_ff @(posedge pclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule : result_fifo

// conversion table, scan sequencer and apb slave
module ring_feedback_conversion
    import ring_feedback_pkg::*;
#(
    parameter int LINES      = 16,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        servo_tick,
    output logic             ring_rd,
    output logic             ring_x_bank,
    output logic [15:0]      ring_addr,
    input  wire logic [23:0] ring_data,
    output logic             result_valid,
    input  wire logic        result_ready,
    output logic [15:0]      result_addr,
    output logic [23:0]      result_data
);
`include "ring_feedback_defs.svh"

    localparam int LW = $clog2(LINES);
    localparam int FW = `RING_ADDR_W + `WORD_W;

    logic [23:0]   tbl_y_q [LINES];
    logic [23:0]   tbl_x_q [LINES];
    logic          enable_q;
    scan_state_t   state_q;
    logic [LW-1:0] line_q;
    method_t       meth_q;
    logic [23:0]   raw_q;
    logic [7:0]    count_q;
    logic [7:0]    last_count_q;
    logic [31:0]   prdata_q;
    logic          pready_q;
    logic          pslverr_q;
    logic          ring_rd_q;
    logic          ring_x_bank_q;
    logic [15:0]   ring_addr_q;
    logic          push;
    logic          fifo_ready;
    logic [23:0]   aligned;
    logic [24:0]   blend;
    logic [23:0]   result;
    logic [LW-1:0] last_line;
    logic [FW-1:0] fifo_out;
    method_t       cur_meth;
    logic [LW:0]   y_idx;
    logic [LW:0]   x_idx;

    // method code to conversion style
    function automatic method_t decode(input logic [7:0] code);
        method_t m;
        m = '0;
        case (code)
            `METH_SHR_Y:      m = '{1'b1, 1'b1, 1'b0, 1'b0};
            `METH_SHR_Y_FILT: m = '{1'b1, 1'b1, 1'b0, 1'b1};
            `METH_SHR_X:      m = '{1'b1, 1'b1, 1'b1, 1'b0};
            `METH_SHR_X_FILT: m = '{1'b1, 1'b1, 1'b1, 1'b1};
            `METH_PAR_Y:      m = '{1'b1, 1'b0, 1'b0, 1'b0};
            `METH_PAR_Y_FILT: m = '{1'b1, 1'b0, 1'b0, 1'b1};
            default:          m = '0;
        endcase
        return m;
    endfunction : decode

    // word index from an apb byte address, or all ones when off the table
    function automatic logic [LW:0] tbl_index(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        if (a >= base && d[1:0] == 2'b00 && d[11:2] < 10'(LINES))
            return {1'b0, d[LW+1:2]};
        return '1;
    endfunction : tbl_index

    // table line under the bus address, top bit set when off the table
    assign y_idx = tbl_index(paddr, `TBL_Y_BASE);
    assign x_idx = tbl_index(paddr, `TBL_X_BASE);

    // setup word of the current line: code in upper byte, address below
    assign cur_meth = decode(tbl_y_q[line_q][23:16]);

    // last line of the entry: second, or third when filtered
    assign last_line = line_q + (meth_q.filtered ? LW'(2) : LW'(1));

    // alignment: type 0 drops three low bits so a count lands at bit 5
    assign aligned = meth_q.shift ? (raw_q >> `SHIFT_COUNT) : raw_q;

    // filter is a plain two-point average with the previous result
    assign blend  = {1'b0, aligned} + {1'b0, tbl_x_q[last_line]};
    assign result = (meth_q.filtered ? blend[24:1] : aligned)
                  & tbl_y_q[line_q + LW'(1)];

    assign push = (state_q == S_STORE) && fifo_ready;

    // scan sequencer, one pass per servo tick taken while idle and enabled, in table order
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q      <= S_IDLE;
            line_q       <= '0;
            meth_q       <= '0;
            raw_q        <= '0;
            count_q      <= '0;
            last_count_q <= '0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (servo_tick && enable_q)
                    begin
                        line_q  <= '0;
                        count_q <= '0;
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    // an unknown code or an entry past the end closes the pass
                    if (!cur_meth.valid
                        || (int'(line_q) + (cur_meth.filtered ? 2 : 1)) >= LINES)
                    begin
                        last_count_q <= count_q;
                        state_q      <= S_IDLE;
                    end
                    else
                    begin
                        meth_q  <= cur_meth;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    raw_q   <= ring_data;
                    state_q <= S_STORE;
                end
                S_STORE:
                begin
                    // full fifo holds the pass here until the reader drains
                    if (fifo_ready)
                    begin
                        count_q <= count_q + 8'h01;
                        if ((int'(last_line) + 1) >= LINES)
                        begin
                            last_count_q <= count_q + 8'h01;
                            state_q      <= S_IDLE;
                        end
                        else
                        begin
                            line_q  <= last_line + LW'(1);
                            state_q <= S_FETCH;
                        end
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ring read request, address held for the answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_rd_q     <= 1'b0;
            ring_x_bank_q <= 1'b0;
            ring_addr_q   <= '0;
        end
        else
        begin
            ring_rd_q <= (state_q == S_FETCH) && cur_meth.valid
                      && (int'(line_q) + (cur_meth.filtered ? 2 : 1)) < LINES;
            if (state_q == S_FETCH)
            begin
                ring_x_bank_q <= cur_meth.x_bank;
                ring_addr_q   <= tbl_y_q[line_q][15:0];
            end
        end
    end

    // processed results into x halves
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < LINES; i++)
                tbl_x_q[i] <= '0;
        end
        else if (push)
        begin
            tbl_x_q[last_line] <= result;
        end
    end

    // apb writes: setup and mask words, control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_q <= `CTRL_RESET;
            for (int i = 0; i < LINES; i++)
                tbl_y_q[i] <= '0;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == `CTRL_OFFSET)
                enable_q <= pwdata[`CTRL_ENABLE_BIT];
            else if (!y_idx[LW])
                tbl_y_q[y_idx[LW-1:0]] <= pwdata[23:0];
        end
    end

    // apb reads prepared in setup, answered with no wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            if (psel && !penable)
            begin
                prdata_q <= '0;
                if (paddr == `CTRL_OFFSET)
                    prdata_q <= {31'h0, enable_q};
                else if (paddr == `STATUS_OFFSET)
                    prdata_q <= {16'h0, last_count_q, 7'h00, state_q != S_IDLE};
                else if (!y_idx[LW])
                    prdata_q <= {8'h00, tbl_y_q[y_idx[LW-1:0]]};
                else if (!x_idx[LW])
                begin
                    if (pwrite)
                        pslverr_q <= 1'b1; // result lines are read-only
                    prdata_q <= {8'h00, tbl_x_q[x_idx[LW-1:0]]};
                end
                else
                    pslverr_q <= 1'b1;
            end
        end
    end

    // results stream to the servo side with their table address
    result_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (state_q == S_STORE),
        .in_ready  (fifo_ready),
        .in_data   ({`TABLE_HOME + 16'(last_line), result}),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (fifo_out)
    );

    assign result_addr = fifo_out[FW-1:`WORD_W];
    assign result_data = fifo_out[`WORD_W-1:0];
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign ring_rd     = ring_rd_q;
    assign ring_x_bank = ring_x_bank_q;
    assign ring_addr   = ring_addr_q;
endmodule : ring_feedback_conversion

//--- ring_feedback_defs.svh
// constants for the ring feedback conversion stage
// assumes a 32-bit apb slave with word-aligned registers
`ifndef RING_FEEDBACK_DEFS_SVH
`define RING_FEEDBACK_DEFS_SVH

// apb byte offsets
`define TBL_Y_BASE     12'h000
`define TBL_X_BASE     12'h100
`define CTRL_OFFSET    12'h200
`define STATUS_OFFSET  12'h204

// ctrl and status fields
`define CTRL_ENABLE_BIT 0
`define STAT_BUSY_BIT   0
`define STAT_COUNT_LSB  8
`define CTRL_RESET      1'b0

// method codes
`define METH_SHR_Y      8'h2C
`define METH_SHR_Y_FILT 8'h3C
`define METH_SHR_X      8'h6C
`define METH_SHR_X_FILT 8'h7C
`define METH_PAR_Y      8'h28
`define METH_PAR_Y_FILT 8'h38

// type 0 alignment and data widths
`define SHIFT_COUNT     3
`define WORD_W          24
`define RING_ADDR_W     16

// table base in controller memory
`define TABLE_HOME      16'h0720

`endif

//--- ring_feedback_pkg.sv
// types for the ring feedback conversion stage
// assumes ring_feedback_defs.svh is included by users of the constants
package ring_feedback_pkg;

    // scan sequencer states
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FETCH = 2'b01,
        S_WAIT  = 2'b10,
        S_STORE = 2'b11
    } scan_state_t;

    // decoded conversion method
    typedef struct packed {
        logic valid;
        logic shift;
        logic x_bank;
        logic filtered;
    } method_t;

endpackage : ring_feedback_pkg

//--- ring_feedback_conversion_properties.sv
// checker for the ring feedback conversion stage
// assumes it is bound to ring_feedback_conversion and sees only its ports
`timescale 1ns/100ps

module ring_feedback_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        ring_rd,
    input wire logic        ring_x_bank,
    input wire logic [15:0] ring_addr,
    input wire logic        result_valid,
    input wire logic        result_ready,
    input wire logic [15:0] result_addr,
    input wire logic [23:0] result_data
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rd_spacing;
        ring_rd |=> !ring_rd [*2];
    endproperty
    a_rd_spacing: assert property (p_rd_spacing) else $error("ring reads too close");

    property p_addr_held;
        ring_rd |=> ($stable(ring_addr) && $stable(ring_x_bank)) [*2];
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("ring source moved");

    property p_rd_to_result;
        ring_rd && !result_valid |-> ##[1:5] result_valid;
    endproperty
    a_rd_to_result: assert property (p_rd_to_result) else $error("no result after read");

    property p_result_range;
        result_valid |-> result_addr >= 16'h0721 && result_addr <= 16'h072F;
    endproperty
    a_result_range: assert property (p_result_range) else $error("result line off table");

    property p_result_hold;
        result_valid && !result_ready |=> result_valid && $stable(result_data) && $stable(result_addr);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result lost while stalled");

    property p_valid_drop;
        $fell(result_valid) |-> $past(result_ready);
    endproperty
    a_valid_drop: assert property (p_valid_drop) else $error("result dropped unpopped");

    property p_upper_zero;
        psel && penable && !pwrite && paddr < 12'h200 |-> prdata[31:24] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("table word above bit 23");

    property p_result_wr_err;
        psel && penable && pwrite && paddr[11:8] == 4'h1 |-> pslverr;
    endproperty
    a_result_wr_err: assert property (p_result_wr_err) else $error("result line write taken");
endmodule : ring_feedback_checker

bind ring_feedback_conversion ring_feedback_checker u_ring_feedback_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .ring_rd(ring_rd),
    .ring_x_bank(ring_x_bank), .ring_addr(ring_addr), .result_valid(result_valid),
    .result_ready(result_ready), .result_addr(result_addr), .result_data(result_data)
);

//--- ring_node_model.sv
// ring node model: feedback registers behind the ring read port
// assumes the design samples the answer while its read request stands
`timescale 1ns/100ps

module ring_node_model (
    input  wire logic        pclk,
    input  wire logic        ring_rd,
    input  wire logic        ring_x_bank,
    input  wire logic [15:0] ring_addr,
    output logic      [23:0] ring_data
);
    logic [23:0] mem [0:511]; // node registers, filled by the bench

    // data stands only while the request does; inverted otherwise so a mistimed sample is caught
    assign ring_data = ring_rd ? mem[{ring_x_bank, ring_addr[7:0]}]
                               : ~mem[{ring_x_bank, ring_addr[7:0]}];
endmodule : ring_node_model

//--- testbench.sv
// self-checking bench for the ring feedback conversion stage
// assumes design, checker and ring node model are compiled before it
`timescale 1ns/100ps
`include "ring_feedback_defs.svh"

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        servo_tick = 1'b0;
    logic        result_ready = 1'b1;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, ring_rd, ring_x_bank, result_valid, er;
    logic [15:0] ring_addr, result_addr;
    logic [23:0] ring_data, result_data;
    int          n_errors = 0;
    int          n_compared = 0;
    int          seed = 63;
    // table entries, software side: one per method code; filtered ones only to reach that path
    logic [23:0] setup_w [6] = '{24'h2CC0A2, 24'h6CC0A6, 24'h28C0A0, 24'h3CC0AA, 24'h7CC0AE, 24'h38C0A4};
    logic [23:0] mask_w  [6] = '{24'h1FFFE0, 24'h01FFE0, 24'hFFFFFF, 24'h1FFFE0, 24'h1FFFE0, 24'hFFFFFF};
    int          first_line [6] = '{0, 2, 4, 6, 9, 12};

    ring_feedback_conversion #(.LINES(16), .FIFO_DEPTH(16)) u_ring_feedback_conversion (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_tick(servo_tick), .ring_rd(ring_rd), .ring_x_bank(ring_x_bank),
        .ring_addr(ring_addr), .ring_data(ring_data), .result_valid(result_valid),
        .result_ready(result_ready), .result_addr(result_addr), .result_data(result_data));

    ring_node_model u_ring_node_model (.pclk(pclk), .ring_rd(ring_rd), .ring_x_bank(ring_x_bank),
        .ring_addr(ring_addr), .ring_data(ring_data));

    // 100 ns clock
    always #50 pclk = ~pclk;

    function automatic logic is_filt(int i);
        return setup_w[i][23:16] inside {`METH_SHR_Y_FILT, `METH_SHR_X_FILT, `METH_PAR_Y_FILT};
    endfunction : is_filt

    function automatic logic is_x(int i);
        return setup_w[i][23:16] inside {`METH_SHR_X, `METH_SHR_X_FILT};
    endfunction : is_x

    // filtered entries keep a third line, so the result moves down one
    function automatic int last_line(int i);
        return first_line[i] + 1 + int'(is_filt(i));
    endfunction : last_line

    function automatic logic [23:0] expect_result(int i);
        logic [23:0] raw;
        raw = u_ring_node_model.mem[{is_x(i), setup_w[i][7:0]}];
        if (!(setup_w[i][23:16] inside {`METH_PAR_Y, `METH_PAR_Y_FILT}))
            raw = raw >> 3;
        return raw & mask_w[i];
    endfunction : expect_result

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle();
        for (int k = 0; k < 40; k++)
        begin
            apb(1'b0, `STATUS_OFFSET, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
    endtask : wait_idle

    task automatic tick();
        @(posedge pclk);
        servo_tick <= 1'b1;
        @(posedge pclk);
        servo_tick <= 1'b0;
    endtask : tick

    // pops n results with a randomly stalling consumer, in table order
    task automatic drain(input int n);
        int i;
        i = 0;
        while (i < n)
        begin
            @(posedge pclk);
            if (result_valid === 1'b1 && result_ready === 1'b1)
            begin
                chk("result_addr", 32'(result_addr), 32'h0720 + 32'(last_line(i % 6)));
                if (is_filt(i % 6))
                    chk("filtered_data", 32'(result_data & ~mask_w[i % 6]), 32'h0);
                else
                    chk("result_data", 32'(result_data), 32'(expect_result(i % 6)));
                i++;
            end
            result_ready <= ($random(seed) % 4) != 0;
        end
    endtask : drain

    // hang guard, far beyond the expected few hundred cycles
    initial
    begin
        #2000000;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and refused accesses
        apb(1'b0, `CTRL_OFFSET, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        apb(1'b0, 12'h300, 32'h0);
        chk("unmapped_err", 32'(er), 32'h1);
        apb(1'b1, `TBL_X_BASE + 12'h004, 32'h123);
        chk("x_write_err", 32'(er), 32'h1);
        apb(1'b0, `TBL_X_BASE + 12'h004, 32'h0);
        chk("x_line_reset", rd, 32'h0);
        // ring registers and conversion table, every method code
        foreach (setup_w[i])
        begin
            u_ring_node_model.mem[{is_x(i), setup_w[i][7:0]}] = 24'($random(seed));
            apb(1'b1, 12'(first_line[i] * 4), {8'h00, setup_w[i]});
            apb(1'b1, 12'(first_line[i] * 4 + 4), {8'h00, mask_w[i]});
        end
        apb(1'b1, 12'h03C, 32'hFF000000); // upper bits dropped, stays an end marker
        apb(1'b0, 12'h03C, 32'h0);
        chk("upper_bits", rd, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("setup_word", rd, 32'h002CC0A2);
        apb(1'b1, `CTRL_OFFSET, 32'h1);
        // one pass, then status and the result line itself
        tick();
        drain(6);
        wait_idle();
        chk("entries", 32'(rd[15:8]), 32'd6);
        apb(1'b1, `STATUS_OFFSET, 32'h0);
        chk("status_write", 32'(er), 32'h0);
        apb(1'b0, `TBL_X_BASE + 12'h004, 32'h0);
        chk("x_line1", rd, 32'(expect_result(0)));
        // three passes into a stopped consumer: fifo fills and the scan stalls
        result_ready <= 1'b0;
        tick();
        wait_idle();
        tick();
        wait_idle();
        tick();
        repeat (100) @(posedge pclk);
        chk("full_valid", 32'(result_valid), 32'h1);
        apb(1'b0, `STATUS_OFFSET, 32'h0);
        chk("stalled_busy", 32'(rd[0]), 32'h1);
        tick(); // ignored while busy
        drain(18);
        repeat (60) @(posedge pclk);
        chk("no_extra_pass", 32'(result_valid), 32'h0);
        print_verdict();
    end
endmodule : testbench
